//--- psl_consts.vh
// constants for the phy strap, indicator and event pin logic
`ifndef PSL_CONSTS_VH
`define PSL_CONSTS_VH

// station manager register offsets
`define PSL_REG_BASIC_CONTROL 5'h00
`define PSL_REG_INT_CTRL_STAT 5'h1B
`define PSL_REG_PHY_CONTROL_1 5'h1E
`define PSL_REG_PHY_CONTROL_2 5'h1F

// field positions
`define PSL_BIT_DUPLEX        8
`define PSL_BIT_ISOLATE       10
`define PSL_BIT_AUTONEG       12
`define PSL_BIT_IRQ_POLARITY  9
`define PSL_BIT_LED_MODE_HI   15
`define PSL_BIT_LED_MODE_LO   14

// indicator modes
`define PSL_LED_LINK_ACT      2'h0
`define PSL_LED_LINK_ONLY     2'h1

// station id low bits, top bits always zero
`define PSL_STATION_ID_LOW    2'h1
`define PSL_STATION_ID_TOP    2'h0

// management frame
`define PSL_OP_READ           2'h2
`define PSL_OP_WRITE          2'h1
`define PSL_HDR_LAST          5'h0B
`define PSL_RD_LAST           5'h10
`define PSL_WR_LAST           5'h11

// timing
`define PSL_CLK_PERIOD_NS     100
`define PSL_BLINK_NS          50000000

`endif

//--- psl_mac_model.sv
// mac and station manager model on the far side of the pins
`timescale 1ns/1ps
`default_nettype none
`include "psl_consts.vh"
module psl_mac_model (
	// clocks
	input  wire logic       clock_in,
	input  wire logic       ref_clk_in,
	// management pins
	input  wire logic       mdio_in,
	output var logic        mdc_out,
	output var logic        md_oe_out,
	output var logic        md_d_out,
	// transmit toward the phy
	output var logic        tx_en_out,
	output var logic [1:0]  txd_out
);
	logic       tx_req = 1'h0;
	logic [1:0] txd_req = 2'h0;
	logic       ref_q = 1'h0;
	initial
	begin
		mdc_out = 1'h0;
		md_oe_out = 1'h0;
		md_d_out = 1'h1;
		tx_en_out = 1'h0;
		txd_out = 2'h0;
	end
	// ==========
	// transmit: new dibit only at reference rise, junk when idle
	always @(posedge clock_in)
	begin
		ref_q <= ref_clk_in;
		if (ref_clk_in && !ref_q)
		begin
			tx_en_out <= tx_req;
			txd_out <= tx_req ? txd_req : ~txd_out;
		end
	end
	// ==========
	// management: mdc rests low between frames
	task mbit(input logic b, output logic s);
		begin
			md_d_out <= b;
			repeat (4) @(posedge clock_in);
			s = mdio_in;
			mdc_out <= 1'h1;
			repeat (4) @(posedge clock_in);
			mdc_out <= 1'h0;
		end
	endtask
	task frame(input logic [1:0] op, input logic [4:0] id, input logic [4:0] ra, input logic [15:0] wd,
		output logic [15:0] rd);
		logic [63:0] f;
		logic        s;
		begin
			f = {32'hFFFFFFFF, 2'h1, op, id, ra, 2'h2, wd};
			md_oe_out <= 1'h1;
			for (int i = 63; i >= -1; i--)
			begin
				if (i == 17 && op == `PSL_OP_READ)
					md_oe_out <= 1'h0;
				mbit(i < 0 ? 1'h1 : f[i], s);
				if (i >= 0 && i < 16)
					rd[i] = s;
			end
			md_oe_out <= 1'h0;
		end
	endtask
endmodule
`default_nettype wire

//--- psl_monitor.sv
// checker watching the top ports of the pin logic
`timescale 1ns/1ps
`default_nettype none
module psl_monitor (
	// clock and reset
	input wire logic       clock_in,
	input wire logic       nrst_in,
	// receive side and pins
	input wire logic       ref_clk_out,
	input wire logic       rx_valid_in,
	input wire logic [1:0] rx_dibit_in,
	input wire logic       rx_err_in,
	input wire logic       station_id_strap_b2_out,
	input wire logic       station_id_strap_b2_oe_n_out,
	input wire logic       duplex_strap_out,
	input wire logic       mode_strap_b2_out,
	input wire logic       mode_strap_b2_oe_n_out,
	input wire logic       isolate_strap_out,
	input wire logic       isolate_strap_oe_n_out,
	input wire logic       indicator_zero_oe_n_out,
	input wire logic       mdio_oe_n_out,
	input wire logic       event_request_pin_out,
	// configuration
	input wire logic [4:0] station_id_out,
	input wire logic [2:0] mode_cfg_out
);
	// ==========
	// helper and defaults
	// up_ff keeps the first edge out, before any reset was seen
	logic up_ff = 1'h0;
	always @(posedge clock_in)
		up_ff <= 1'h1;
	default clocking cb @(posedge clock_in); endclocking
	default disable iff (!nrst_in);
	// ==========
	// assertions
	id_top_a: assert property (station_id_out[4:3] == 2'h0)
		else $error("station id top bits not zero");
	ref_tog_a: assert property ($past(nrst_in, 2) |-> ref_clk_out != $past(ref_clk_out))
		else $error("reference clock did not toggle");
	crs_out_a: assert property (!ref_clk_out && rx_valid_in |=> mode_strap_b2_oe_n_out || mode_strap_b2_out)
		else $error("carrier valid not shown");
	rxd_out_a: assert property (!ref_clk_out && rx_valid_in |=> station_id_strap_b2_oe_n_out
		|| {station_id_strap_b2_out, duplex_strap_out} == $past(rx_dibit_in))
		else $error("receive dibit wrong");
	rxer_out_a: assert property (!ref_clk_out && rx_valid_in && rx_err_in |=> isolate_strap_oe_n_out
		|| isolate_strap_out)
		else $error("receive error not flagged");
	led_drv_a: assert property ($past(nrst_in, 2) |-> !indicator_zero_oe_n_out)
		else $error("indicator not driven");
	pin_rel_a: assert property (disable iff (1'h0) up_ff && $past(!nrst_in) |-> station_id_strap_b2_oe_n_out
		&& mode_strap_b2_oe_n_out && isolate_strap_oe_n_out && indicator_zero_oe_n_out
		&& mdio_oe_n_out && event_request_pin_out)
		else $error("pin driven during reset");
	cfg_hold_a: assert property ($past(nrst_in) |-> $stable(mode_cfg_out) && $stable(station_id_out))
		else $error("strap capture changed");
	cover property (rx_valid_in && !ref_clk_out);
	cover property ($fell(event_request_pin_out));
	cover property ($fell(mdio_oe_n_out));
endmodule
bind psl_top psl_monitor psl_monitor_inst (.*);
`default_nettype wire

//--- psl_sync.v
// two-flop synchroniser for pins arriving from outside the clock domain
`timescale 1ns/1ps
`default_nettype none

module psl_sync #(
	parameter W = 12
) (
	// clock
	input  wire         clock_in,
	// data
	input  wire [W-1:0] async_in,
	output wire [W-1:0] sync_out
);

// ==================================================
// two stages
reg [W-1:0] meta_ff;
reg [W-1:0] sync_ff;

// no reset: strap levels must keep flowing while reset is held
always @(posedge clock_in)
begin
	meta_ff <= async_in;
	sync_ff <= meta_ff;
end

assign sync_out = sync_ff;

endmodule

`default_nettype wire

//--- psl_top.v
// phy pin logic: straps, receive outputs, reference clock, event pin, indicator, management registers
`timescale 1ns/1ps
`default_nettype none
`include "psl_consts.vh"

module psl_top #(
	parameter BLINK_CYCLES = `PSL_BLINK_NS / `PSL_CLK_PERIOD_NS
) (
	// clock and reset
	input  wire       clock_in,
	input  wire       nrst_in,
	// dual-role pins toward the mac
	input  wire       station_id_strap_b2_in,
	output wire       station_id_strap_b2_out,
	output wire       station_id_strap_b2_oe_n_out,
	input  wire       duplex_strap_in,
	output wire       duplex_strap_out,
	output wire       duplex_strap_oe_n_out,
	input  wire       mode_strap_b2_in,
	output wire       mode_strap_b2_out,
	output wire       mode_strap_b2_oe_n_out,
	input  wire       isolate_strap_in,
	output wire       isolate_strap_out,
	output wire       isolate_strap_oe_n_out,
	input  wire       mode_strap_b0_in,
	output wire       mode_strap_b0_out,
	output wire       mode_strap_b0_oe_n_out,
	input  wire       mode_strap_b1_in,
	output wire       mode_strap_b1_out,
	output wire       mode_strap_b1_oe_n_out,
	input  wire       autoneg_strap_in,
	output wire       indicator_zero_out,
	output wire       indicator_zero_oe_n_out,
	// reference clock and transmit from the mac
	output wire       ref_clk_out,
	input  wire       tx_en_in,
	input  wire [1:0] txd_in,
	// station management
	input  wire       mdc_in,
	input  wire       mdio_in,
	output wire       mdio_out,
	output wire       mdio_oe_n_out,
	// event pin
	output wire       event_request_pin_out,
	// internal receiver side
	input  wire       rx_valid_in,
	input  wire [1:0] rx_dibit_in,
	input  wire       rx_err_in,
	input  wire       link_up_in,
	input  wire       activity_in,
	input  wire [7:0] event_in,
	// internal transmitter side
	output wire       tx_valid_out,
	output wire [1:0] tx_dibit_out,
	// configuration seen by the core
	output wire [4:0] station_id_out,
	output wire [2:0] mode_cfg_out,
	output wire [15:0] basic_control_out
);

// ==================================================
// state codes
localparam [2:0] ST_IDLE = 3'h0;
localparam [2:0] ST_HDR  = 3'h1;
localparam [2:0] ST_TA   = 3'h2;
localparam [2:0] ST_RD   = 3'h3;
localparam [2:0] ST_WR   = 3'h4;
localparam [2:0] ST_SKIP = 3'h5;

function rise;
	input prev;
	input cur;
	begin
		rise = cur & ~prev;
	end
endfunction

// ==================================================
// pin synchronisers
wire [11:0] pin_sync;

psl_sync #(
	.W (12)
) u_sync (
	.clock_in (clock_in),
	.async_in ({mdc_in, mdio_in, tx_en_in, txd_in, station_id_strap_b2_in, duplex_strap_in,
	            mode_strap_b2_in, isolate_strap_in, mode_strap_b0_in, mode_strap_b1_in, autoneg_strap_in}),
	.sync_out (pin_sync)
);

wire       s_mdc   = pin_sync[11];
wire       s_mdio  = pin_sync[10];
wire       s_tx_en = pin_sync[9];
wire [1:0] s_txd   = pin_sync[8:7];

// ==================================================
// strap capture
reg        station_b2_ff;
reg [2:0]  mode_ff;
reg        released_ff;
reg        rst_prev_ff;
reg [15:0] bcr_ff;
reg [7:0]  int_en_ff;
reg [7:0]  int_st_ff;
reg [1:0]  led_mode_ff;
reg        irq_pol_ff;

// keep sampling while held, so the last sample is the one at release
always @(posedge clock_in)
begin
	rst_prev_ff <= nrst_in;
	if (!nrst_in)
	begin
		station_b2_ff <= pin_sync[6];
		mode_ff       <= {pin_sync[4], pin_sync[1], pin_sync[2]};
		released_ff   <= 1'b0;
	end
	else if (rise(rst_prev_ff, nrst_in))
		released_ff <= 1'b1;
end

assign station_id_out = {`PSL_STATION_ID_TOP, station_b2_ff, `PSL_STATION_ID_LOW};
assign mode_cfg_out   = mode_ff;

wire iso = bcr_ff[`PSL_BIT_ISOLATE];
// receive pins toward the mac float while isolated
wire mac_oe_n = ~released_ff | iso;

// ==================================================
// reference clock and rmii datapath
reg       ref_ff;
reg [1:0] rxd_ff;
reg       crs_dv_ff;
reg       rx_er_ff;
reg [1:0] txd_ff;
reg       tx_val_ff;

// only reachable rate from this clock is half of it
wire ref_en = ~ref_ff;

always @(posedge clock_in)
begin
	if (!nrst_in)
	begin
		ref_ff    <= 1'b0;
		rxd_ff    <= 2'h0;
		crs_dv_ff <= 1'b0;
		rx_er_ff  <= 1'b0;
		txd_ff    <= 2'h0;
		tx_val_ff <= 1'b0;
	end
	else
	begin
		ref_ff <= ~ref_ff;
		if (ref_en)
		begin
			crs_dv_ff <= rx_valid_in;
			rxd_ff    <= rx_valid_in ? rx_dibit_in : 2'h0;
			rx_er_ff  <= rx_valid_in & rx_err_in;
			tx_val_ff <= s_tx_en;
			txd_ff    <= s_tx_en ? s_txd : 2'h0;
		end
	end
end

assign ref_clk_out                  = ref_ff;
assign station_id_strap_b2_out      = rxd_ff[1];
assign duplex_strap_out             = rxd_ff[0];
assign mode_strap_b2_out            = crs_dv_ff;
assign isolate_strap_out            = rx_er_ff;
assign station_id_strap_b2_oe_n_out = mac_oe_n;
assign duplex_strap_oe_n_out        = mac_oe_n;
assign mode_strap_b2_oe_n_out       = mac_oe_n;
assign isolate_strap_oe_n_out       = mac_oe_n;
// dedicated mode pins have no run-time job, drive low once released
assign mode_strap_b0_out            = 1'b0;
assign mode_strap_b1_out            = 1'b0;
assign mode_strap_b0_oe_n_out       = ~released_ff;
assign mode_strap_b1_oe_n_out       = ~released_ff;
assign tx_valid_out                 = tx_val_ff;
assign tx_dibit_out                 = txd_ff;

// ==================================================
// management frame engine
reg [2:0]  st_ff;
reg [4:0]  cnt_ff;
reg [1:0]  pre_ff;
reg [11:0] hdr_ff;
reg [15:0] dat_ff;
reg [4:0]  addr_ff;
reg        mdc_prev_ff;
reg        mdio_o_ff;
reg        mdio_oe_n_ff;
reg        wr_stb_ff;
reg        rd_clr_ff;
reg [7:0]  clr_mask_ff;

wire        mdc_rise = rise(mdc_prev_ff, s_mdc);
wire [11:0] hdr_full = {hdr_ff[10:0], s_mdio};
reg  [15:0] rd_data;

always @*
begin
	case (hdr_full[4:0])
		`PSL_REG_BASIC_CONTROL: rd_data = bcr_ff;
		`PSL_REG_INT_CTRL_STAT: rd_data = {int_en_ff, int_st_ff};
		`PSL_REG_PHY_CONTROL_1: rd_data = {led_mode_ff, 14'h0000};
		`PSL_REG_PHY_CONTROL_2: rd_data = {6'h00, irq_pol_ff, 9'h000};
		default:                rd_data = 16'h0000;
	endcase
end

always @(posedge clock_in)
begin
	if (!nrst_in)
	begin
		st_ff        <= ST_IDLE;
		cnt_ff       <= 5'h00;
		pre_ff       <= 2'h0;
		hdr_ff       <= 12'h000;
		dat_ff       <= 16'h0000;
		addr_ff      <= 5'h00;
		mdc_prev_ff  <= 1'b0;
		mdio_o_ff    <= 1'b1;
		mdio_oe_n_ff <= 1'b1;
		wr_stb_ff    <= 1'b0;
		rd_clr_ff    <= 1'b0;
		clr_mask_ff  <= 8'h00;
	end
	else
	begin
		mdc_prev_ff <= s_mdc;
		wr_stb_ff   <= 1'b0;
		rd_clr_ff   <= 1'b0;
		if (mdc_rise)
		begin
			case (st_ff)
				ST_IDLE:
				begin
					pre_ff <= {pre_ff[0], s_mdio};
					// a one, then start bits zero-one
					if ({pre_ff, s_mdio} == 3'h5)
					begin
						st_ff  <= ST_HDR;
						cnt_ff <= 5'h00;
					end
				end
				ST_HDR:
				begin
					hdr_ff <= hdr_full;
					cnt_ff <= cnt_ff + 5'h01;
					if (cnt_ff == `PSL_HDR_LAST)
					begin
						cnt_ff  <= 5'h00;
						addr_ff <= hdr_full[4:0];
						if (hdr_full[9:5] != station_id_out)
							st_ff <= ST_SKIP;
						else if (hdr_full[11:10] == `PSL_OP_READ)
						begin
							st_ff  <= ST_TA;
							dat_ff <= rd_data;
							if (hdr_full[4:0] == `PSL_REG_INT_CTRL_STAT)
							begin
								rd_clr_ff   <= 1'b1;
								clr_mask_ff <= int_st_ff;
							end
						end
						else if (hdr_full[11:10] == `PSL_OP_WRITE)
							st_ff <= ST_WR;
						else
							st_ff <= ST_SKIP;
					end
				end
				ST_TA:
				begin
					mdio_o_ff    <= 1'b0;
					mdio_oe_n_ff <= 1'b0;
					st_ff        <= ST_RD;
				end
				ST_RD:
				begin
					cnt_ff <= cnt_ff + 5'h01;
					if (cnt_ff == `PSL_RD_LAST)
					begin
						mdio_o_ff    <= 1'b1;
						mdio_oe_n_ff <= 1'b1;
						pre_ff       <= 2'h0;
						st_ff        <= ST_IDLE;
					end
					else
					begin
						mdio_o_ff <= dat_ff[15];
						dat_ff    <= {dat_ff[14:0], 1'b0};
					end
				end
				ST_WR:
				begin
					dat_ff <= {dat_ff[14:0], s_mdio};
					cnt_ff <= cnt_ff + 5'h01;
					if (cnt_ff == `PSL_WR_LAST)
					begin
						wr_stb_ff <= 1'b1;
						pre_ff    <= 2'h0;
						st_ff     <= ST_IDLE;
					end
				end
				ST_SKIP:
				begin
					cnt_ff <= cnt_ff + 5'h01;
					if (cnt_ff == `PSL_WR_LAST)
					begin
						pre_ff <= 2'h0;
						st_ff  <= ST_IDLE;
					end
				end
				default:
					st_ff <= ST_IDLE;
			endcase
		end
	end
end

assign mdio_out      = mdio_o_ff;
assign mdio_oe_n_out = mdio_oe_n_ff;

// ==================================================
// register file
always @(posedge clock_in)
begin
	if (!nrst_in)
	begin
		bcr_ff                   <= 16'h0000;
		bcr_ff[`PSL_BIT_DUPLEX]  <= pin_sync[5];
		bcr_ff[`PSL_BIT_ISOLATE] <= pin_sync[3];
		bcr_ff[`PSL_BIT_AUTONEG] <= pin_sync[0];
		int_en_ff                <= 8'h00;
		int_st_ff                <= 8'h00;
		led_mode_ff              <= `PSL_LED_LINK_ACT;
		irq_pol_ff               <= 1'b0;
	end
	else
	begin
		// set wins over the clear-on-read
		int_st_ff <= (int_st_ff & ~(rd_clr_ff ? clr_mask_ff : 8'h00)) | event_in;
		if (wr_stb_ff)
		begin
			case (addr_ff)
				`PSL_REG_BASIC_CONTROL: bcr_ff      <= dat_ff;
				`PSL_REG_INT_CTRL_STAT: int_en_ff   <= dat_ff[15:8];
				`PSL_REG_PHY_CONTROL_1: led_mode_ff <= dat_ff[`PSL_BIT_LED_MODE_HI:`PSL_BIT_LED_MODE_LO];
				`PSL_REG_PHY_CONTROL_2: irq_pol_ff  <= dat_ff[`PSL_BIT_IRQ_POLARITY];
				default:                bcr_ff      <= bcr_ff;
			endcase
		end
	end
end

assign basic_control_out = bcr_ff;

// ==================================================
// event pin and indicator
reg        irq_ff;
reg        led_ff;
reg        blink_ff;
reg [18:0] blink_cnt_ff;

always @(posedge clock_in)
begin
	if (!nrst_in)
	begin
		irq_ff       <= 1'b1;
		led_ff       <= 1'b1;
		blink_ff     <= 1'b0;
		blink_cnt_ff <= 19'h00000;
	end
	else
	begin
		irq_ff <= irq_pol_ff ~^ (|(int_en_ff & int_st_ff));
		if (blink_cnt_ff == BLINK_CYCLES[18:0] - 19'h00001)
		begin
			blink_cnt_ff <= 19'h00000;
			blink_ff     <= ~blink_ff;
		end
		else
			blink_cnt_ff <= blink_cnt_ff + 19'h00001;
		case (led_mode_ff)
			`PSL_LED_LINK_ACT:  led_ff <= ~link_up_in | (activity_in & blink_ff);
			`PSL_LED_LINK_ONLY: led_ff <= ~link_up_in;
			default:            led_ff <= 1'b1;
		endcase
	end
end

assign event_request_pin_out   = irq_ff;
assign indicator_zero_out      = led_ff;
assign indicator_zero_oe_n_out = ~released_ff;

endmodule

`default_nettype wire

//--- psl_top_bench.sv
// self-checking bench for the phy pin logic
`timescale 1ns/1ps
`default_nettype none
`include "psl_consts.vh"
module psl_top_bench;
	// ==========
	// signals
	logic        clock_in = 1'h0;
	logic        nrst_in = 1'h0;
	logic [6:0]  st = 7'h00;
	logic        rx_valid_in = 1'h0;
	logic [1:0]  rx_dibit_in = 2'h0;
	logic        rx_err_in = 1'h0;
	logic        link_up_in = 1'h0;
	logic        activity_in = 1'h0;
	logic [7:0]  event_in = 8'h00;
	logic [4:0]  sid = 5'h05;
	logic [15:0] rd;
	int          err_total = 0;
	int          compares = 0;
	wire         mdc, md_oe, md_d, tx_en, mdio_out, mdio_oe_n_out, ref_clk_out, event_request_pin_out;
	wire [1:0]   txd, tx_dibit_out;
	wire         station_id_strap_b2_out, station_id_strap_b2_oe_n_out, duplex_strap_out, duplex_strap_oe_n_out;
	wire         mode_strap_b2_out, mode_strap_b2_oe_n_out, isolate_strap_out, isolate_strap_oe_n_out;
	wire         mode_strap_b0_out, mode_strap_b0_oe_n_out, mode_strap_b1_out, mode_strap_b1_oe_n_out;
	wire         indicator_zero_out, indicator_zero_oe_n_out, tx_valid_out;
	wire [4:0]   station_id_out;
	wire [2:0]   mode_cfg_out;
	wire [15:0]  basic_control_out;
	// released management line rests at its pull-up
	wire         mdio_w = !mdio_oe_n_out ? mdio_out : (md_oe ? md_d : 1'h1);
	always #50 clock_in = ~clock_in;
	// ==========
	// design and partner; released straps show their pull level
	psl_top #(.BLINK_CYCLES(8)) psl_top_inst (
		.*,
		.station_id_strap_b2_in(station_id_strap_b2_oe_n_out ? st[0] : station_id_strap_b2_out),
		.duplex_strap_in(duplex_strap_oe_n_out ? st[1] : duplex_strap_out),
		.mode_strap_b2_in(mode_strap_b2_oe_n_out ? st[2] : mode_strap_b2_out),
		.isolate_strap_in(isolate_strap_oe_n_out ? st[3] : isolate_strap_out),
		.mode_strap_b0_in(mode_strap_b0_oe_n_out ? st[4] : mode_strap_b0_out),
		.mode_strap_b1_in(mode_strap_b1_oe_n_out ? st[5] : mode_strap_b1_out),
		.autoneg_strap_in(indicator_zero_oe_n_out ? st[6] : indicator_zero_out),
		.tx_en_in(tx_en),
		.txd_in(txd),
		.mdc_in(mdc),
		.mdio_in(mdio_w)
	);
	psl_mac_model psl_mac_model_inst (
		.clock_in(clock_in),
		.ref_clk_in(ref_clk_out),
		.mdio_in(mdio_w),
		.mdc_out(mdc),
		.md_oe_out(md_oe),
		.md_d_out(md_d),
		.tx_en_out(tx_en),
		.txd_out(txd)
	);
	// ==========
	// shared tasks
	task chk(input logic [15:0] got, input logic [15:0] exp);
		begin
			compares++;
			if (got !== exp)
			begin
				err_total++;
				$display("Error at %0t: got %h expected %h", $time, got, exp);
			end
		end
	endtask
	task tick(input int n);
		begin
			repeat (n) @(posedge clock_in);
			@(negedge clock_in);
		end
	endtask
	task mg(input logic [1:0] op, input logic [4:0] ra, input logic [15:0] wd);
		begin
			@(posedge clock_in);
			psl_mac_model_inst.frame(op, sid, ra, wd, rd);
			tick(4);
		end
	endtask
	task pulse(input logic [7:0] ev);
		begin
			@(posedge clock_in);
			event_in <= ev;
			@(posedge clock_in);
			event_in <= 8'h00;
			tick(3);
		end
	endtask
	task test_done;
		begin
			$display("compares %0d errors %0d", compares, err_total);
			if (err_total == 0 && compares > 0)
				$display("bench passed");
			else
				$display("bench failed");
			$finish;
		end
	endtask
	// ==========
	// scenarios
	task t_reset(input logic [6:0] s);
		begin
			@(posedge clock_in);
			nrst_in <= 1'h0;
			st <= s;
			sid = {2'h0, s[0], 2'h1};
			tick(4);
			chk({station_id_strap_b2_oe_n_out, mode_strap_b2_oe_n_out, isolate_strap_oe_n_out,
				indicator_zero_oe_n_out, mdio_oe_n_out, event_request_pin_out}, 16'h003F);
			@(posedge clock_in);
			nrst_in <= 1'h1;
			tick(3);
			chk(station_id_out, sid);
			chk(mode_cfg_out, {s[2], s[5], s[4]});
			chk({isolate_strap_oe_n_out, mode_strap_b2_oe_n_out, indicator_zero_oe_n_out}, {s[3], s[3], 1'h0});
			chk({duplex_strap_oe_n_out, mode_strap_b0_oe_n_out, mode_strap_b1_oe_n_out, mode_strap_b0_out,
				mode_strap_b1_out}, {s[3], 4'h0});
			chk(basic_control_out & 16'h1500, {3'h0, s[6], 1'h0, s[3], 1'h0, s[1], 8'h00});
			mg(`PSL_OP_READ, `PSL_REG_BASIC_CONTROL, 16'h0000);
			chk(rd & 16'h1500, {3'h0, s[6], 1'h0, s[3], 1'h0, s[1], 8'h00});
		end
	endtask
	task t_rx(input logic [1:0] d, input logic e);
		int   n;
		logic p;
		begin
			n = 0;
			p = ref_clk_out;
			repeat (10)
			begin
				tick(1);
				n += (ref_clk_out !== p);
				p = ref_clk_out;
			end
			chk(n, 10);
			@(posedge clock_in);
			rx_valid_in <= 1'h1;
			rx_dibit_in <= d;
			rx_err_in <= e;
			tick(4);
			chk({mode_strap_b2_out, station_id_strap_b2_out, duplex_strap_out, isolate_strap_out}, {1'h1, d, e});
			@(posedge clock_in);
			rx_valid_in <= 1'h0;
			tick(4);
			chk(mode_strap_b2_out, 1'h0);
		end
	endtask
	task t_tx(input logic [1:0] d);
		begin
			psl_mac_model_inst.txd_req = d;
			psl_mac_model_inst.tx_req = 1'h1;
			tick(10);
			chk({tx_valid_out, tx_dibit_out}, {1'h1, d});
			psl_mac_model_inst.tx_req = 1'h0;
			tick(10);
			chk(tx_valid_out, 1'h0);
		end
	endtask
	task t_irq;
		begin
			mg(`PSL_OP_WRITE, `PSL_REG_INT_CTRL_STAT, 16'h0100);
			pulse(8'h02);
			chk(event_request_pin_out, 1'h1);
			pulse(8'h01);
			chk(event_request_pin_out, 1'h0);
			mg(`PSL_OP_READ, `PSL_REG_INT_CTRL_STAT, 16'h0000);
			chk(rd, 16'h0103);
			chk(event_request_pin_out, 1'h1);
			mg(`PSL_OP_WRITE, `PSL_REG_PHY_CONTROL_2, 16'h0200);
			chk(event_request_pin_out, 1'h0);
			pulse(8'h01);
			chk(event_request_pin_out, 1'h1);
			// foreign station and an unused op code must both be skipped
			@(posedge clock_in);
			psl_mac_model_inst.frame(`PSL_OP_WRITE, sid ^ 5'h02, `PSL_REG_PHY_CONTROL_2, 16'h0000, rd);
			@(posedge clock_in);
			psl_mac_model_inst.frame(2'h3, sid, `PSL_REG_PHY_CONTROL_2, 16'h0000, rd);
			tick(4);
			mg(`PSL_OP_READ, `PSL_REG_PHY_CONTROL_2, 16'h0000);
			chk(rd, 16'h0200);
			mg(`PSL_OP_READ, 5'h05, 16'h0000);
			chk(rd, 16'h0000);
		end
	endtask
	task t_led(input logic [1:0] m, input logic lk, input logic ac, input logic lvl, input logic tg);
		int   n;
		logic p;
		begin
			mg(`PSL_OP_WRITE, `PSL_REG_PHY_CONTROL_1, {m, 14'h0000});
			@(posedge clock_in);
			link_up_in <= lk;
			activity_in <= ac;
			tick(4);
			p = indicator_zero_out;
			n = 0;
			repeat (40)
			begin
				tick(1);
				n += (indicator_zero_out !== p);
				p = indicator_zero_out;
			end
			chk(n != 0, tg);
			if (!tg)
				chk(indicator_zero_out, lvl);
		end
	endtask
	// ==========
	// main sequence and watchdog
	initial
	begin
		t_reset(7'h08);
		t_reset(7'h67);
		t_rx(2'h2, 1'h1);
		t_rx(2'h1, 1'h0);
		t_tx(2'h3);
		t_irq;
		t_led(2'h0, 1'h0, 1'h0, 1'h1, 1'h0);
		t_led(2'h0, 1'h1, 1'h0, 1'h0, 1'h0);
		t_led(2'h0, 1'h1, 1'h1, 1'h0, 1'h1);
		t_led(2'h1, 1'h1, 1'h1, 1'h0, 1'h0);
		t_led(2'h2, 1'h1, 1'h1, 1'h1, 1'h0);
		t_led(2'h3, 1'h1, 1'h1, 1'h1, 1'h0);
		test_done;
	end
	initial
	begin
		repeat (40000) @(posedge clock_in);
		err_total++;
		test_done;
	end
endmodule
`default_nettype wire
